// ===== verilog/tlc_map.svh
// Offsets, field positions, reset values and fixed-point constants of the loss block.
// Assumes inclusion by name from the package and the top module.
`ifndef TLC_MAP_SVH
`define TLC_MAP_SVH
`define TLC_OFF_CTRL 8'h00
`define TLC_OFF_IRON_W 8'h04
`define TLC_OFF_COPPER_W 8'h08
`define TLC_OFF_IRON_V 8'h0c
`define TLC_OFF_COPPER_V 8'h10
`define TLC_OFF_STATUS 8'h14
`define TLC_BIT_IRON_EN 0
`define TLC_BIT_COPPER_EN 1
`define TLC_BIT_ADD 2
`define TLC_BIT_FLOW_REV 3
`define TLC_BIT_TEST 4
`define TLC_CTRL_W 5
`define TLC_CTRL_RST 5'h00
`define TLC_PCT_RST 16'h0000
// Meter base 120 V in 10 mV steps, 5 A in 1 mA steps
`define TLC_VCAL 16'h2ee0
`define TLC_ICAL 16'h1388
// Reciprocals 2^24/cal, so a ratio comes out with 14 fraction bits
`define TLC_VINV 12'h576
`define TLC_IINV 12'hd1b
`define TLC_RATIO_SH 10
`define TLC_FRAC 14
`define TLC_PROD_SH 30
// Full-scale secondary 600 VA in mW
`define TLC_FSVA_MW 20'h927c0
`define TLC_LATENCY 3
`define TLC_RESP_OKAY 2'b00
`define TLC_RESP_SLVERR 2'b10
`endif

// ===== verilog/tlc_pkg.sv
// Types shared by the loss block and its surroundings.
// Assumes the map header sits beside it.
`include "tlc_map.svh"
package tlc_pkg;
	typedef struct packed {
		logic [15:0] volt;
		logic [15:0] curr;
		logic signed [31:0] watt;
		logic signed [31:0] vars;
	} tlc_meas_t;
	typedef struct packed {
		logic signed [31:0] watt;
		logic signed [31:0] vars;
	} tlc_res_t;
	typedef struct packed {
		logic test;
		logic flow_rev;
		logic add;
		logic copper_en;
		logic iron_en;
	} tlc_ctrl_t;
endpackage : tlc_pkg

// ===== verilog/tlc_top.sv
// Per-phase transformer loss compensation with an AXI4-Lite register slave.
// Assumes one reading strobe per second carrying all phases, synchronous to CLOCK.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "tlc_map.svh"

module tlc_top import tlc_pkg::*; #(
	parameter int PHASES = 3
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic MEAS_VALID,
	input wire tlc_meas_t [PHASES-1:0] MEAS_IN,
	output logic OUT_VALID,
	output tlc_res_t [PHASES-1:0] OUT_DATA,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	////////////////////////////////////////////////////////////////////////////////
	tlc_ctrl_t ctrl, next_ctrl;
	logic [15:0] pct [4];
	logic [15:0] next_pct [4];
	logic [15:0] res_count, next_res_count;
	logic aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [31:0] rdata, next_rdata;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_ctrl = ctrl;
		next_pct = pct;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		next_res_count = OUT_VALID ? res_count + 16'h0001 : res_count;
		if (S_AXI_AWVALID && !aw_held) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !w_held) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA;
			next_w_strb = S_AXI_WSTRB;
		end
		if (bvalid && S_AXI_BREADY)
			next_bvalid = 1'b0;
		// Both halves in hand and the last answer gone: commit the write
		if (aw_held && w_held && !bvalid) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `TLC_RESP_OKAY;
			unique case (aw_addr)
				`TLC_OFF_CTRL: if (w_strb[0]) next_ctrl = tlc_ctrl_t'(w_data[`TLC_CTRL_W-1:0]);
				`TLC_OFF_IRON_W, `TLC_OFF_COPPER_W, `TLC_OFF_IRON_V, `TLC_OFF_COPPER_V: begin
					if (w_strb[0]) next_pct[aw_addr[3:2]-2'h1][7:0] = w_data[7:0];
					if (w_strb[1]) next_pct[aw_addr[3:2]-2'h1][15:8] = w_data[15:8];
				end
				`TLC_OFF_STATUS: ;
				default: next_bresp = `TLC_RESP_SLVERR;
			endcase
		end
		if (rvalid && S_AXI_RREADY)
			next_rvalid = 1'b0;
		if (S_AXI_ARVALID && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp = `TLC_RESP_OKAY;
			unique case (S_AXI_ARADDR)
				`TLC_OFF_CTRL: next_rdata = {27'h0, ctrl};
				`TLC_OFF_IRON_W: next_rdata = {16'h0, pct[0]};
				`TLC_OFF_COPPER_W: next_rdata = {16'h0, pct[1]};
				`TLC_OFF_IRON_V: next_rdata = {16'h0, pct[2]};
				`TLC_OFF_COPPER_V: next_rdata = {16'h0, pct[3]};
				`TLC_OFF_STATUS: next_rdata = {16'h0, res_count};
				default: begin
					next_rdata = 32'h0;
					next_rresp = `TLC_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `TLC_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `TLC_RESP_OKAY;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_ARREADY <= 1'b1;
			ctrl <= tlc_ctrl_t'(`TLC_CTRL_RST);
			for (int k = 0; k < 4; k++)
				pct[k] <= `TLC_PCT_RST;
			res_count <= 16'h0000;
		end else begin
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			S_AXI_AWREADY <= ~next_aw_held;
			S_AXI_WREADY <= ~next_w_held;
			S_AXI_ARREADY <= ~next_rvalid;
			ctrl <= next_ctrl;
			pct <= next_pct;
			res_count <= next_res_count;
		end
	end

	// Ready flags are registered inverses of the next holding state; ARREADY inverts the next read valid
	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RDATA = rdata;
	assign S_AXI_RRESP = rresp;

	////////////////////////////////////////////////////////////////////////////////
	// Three-stage pipeline; the control bits are snapshotted with the reading so a control
	// write mid-flight cannot mix two modes in one result; the loss percentages are read live in stage two.
	logic v1, v2, next_v1, next_v2, next_out_valid;
	tlc_ctrl_t c1, c2, next_c1, next_c2;
	tlc_res_t [PHASES-1:0] m1, m2, next_m1, next_m2, next_out;
	logic [17:0] rv [PHASES];
	logic [17:0] ri [PHASES];
	logic [17:0] next_rv [PHASES];
	logic [17:0] next_ri [PHASES];
	logic [47:0] wsum [PHASES];
	logic [47:0] vsum [PHASES];
	logic [47:0] next_wsum [PHASES];
	logic [47:0] next_vsum [PHASES];

	always_comb begin
		logic [21:0] rv2, ri2;
		logic [29:0] rv4;
		logic [67:0] wl, vl;
		logic signed [31:0] wloss, vloss;
		rv2 = 22'h0;
		ri2 = 22'h0;
		rv4 = 30'h0;
		wl = 68'h0;
		vl = 68'h0;
		wloss = 32'sh0;
		vloss = 32'sh0;
		next_v1 = MEAS_VALID;
		next_v2 = v1;
		next_out_valid = v2;
		next_c1 = MEAS_VALID ? ctrl : c1;
		next_c2 = c1;
		next_m2 = m1;
		next_m1 = m1;
		next_out = OUT_DATA;
		for (int p = 0; p < PHASES; p++) begin
			// Ratios against 120 V / 5 A, 14 fraction bits
			next_rv[p] = MEAS_VALID ? 18'((28'(MEAS_IN[p].volt) * `TLC_VINV) >> `TLC_RATIO_SH) : rv[p];
			next_ri[p] = MEAS_VALID ? 18'((28'(MEAS_IN[p].curr) * `TLC_IINV) >> `TLC_RATIO_SH) : ri[p];
			if (MEAS_VALID) begin
				next_m1[p].watt = MEAS_IN[p].watt;
				next_m1[p].vars = MEAS_IN[p].vars;
			end
			rv2 = 22'((36'(rv[p]) * 36'(rv[p])) >> `TLC_FRAC);
			ri2 = 22'((36'(ri[p]) * 36'(ri[p])) >> `TLC_FRAC);
			rv4 = 30'((44'(rv2) * 44'(rv2)) >> `TLC_FRAC);
			next_wsum[p] = (c1.iron_en ? 48'(rv2) * 48'(pct[0]) : 48'h0)
				+ (c1.copper_en ? 48'(ri2) * 48'(pct[1]) : 48'h0);
			next_vsum[p] = (c1.iron_en ? 48'(rv4) * 48'(pct[2]) : 48'h0)
				+ (c1.copper_en ? 48'(ri2) * 48'(pct[3]) : 48'h0);
			// Scale to full-scale VA; no saturation, settings keep losses small
			wl = 68'(wsum[p]) * 68'(`TLC_FSVA_MW);
			vl = 68'(vsum[p]) * 68'(`TLC_FSVA_MW);
			wloss = $signed(wl[`TLC_PROD_SH +: 32]);
			vloss = $signed(vl[`TLC_PROD_SH +: 32]);
			if (v2) begin
				if (c2.test) begin
					next_out[p] = m2[p];
				end else if (c2.add ^ c2.flow_rev) begin
					next_out[p].watt = m2[p].watt - wloss;
					next_out[p].vars = m2[p].vars - vloss;
				end else begin
					next_out[p].watt = m2[p].watt + wloss;
					next_out[p].vars = m2[p].vars + vloss;
				end
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			v1 <= 1'b0;
			v2 <= 1'b0;
			OUT_VALID <= 1'b0;
			c1 <= tlc_ctrl_t'(`TLC_CTRL_RST);
			c2 <= tlc_ctrl_t'(`TLC_CTRL_RST);
			m1 <= '0;
			m2 <= '0;
			OUT_DATA <= '0;
			for (int p = 0; p < PHASES; p++) begin
				rv[p] <= 18'h0;
				ri[p] <= 18'h0;
				wsum[p] <= 48'h0;
				vsum[p] <= 48'h0;
			end
		end else begin
			v1 <= next_v1;
			v2 <= next_v2;
			OUT_VALID <= next_out_valid;
			c1 <= next_c1;
			c2 <= next_c2;
			m1 <= next_m1;
			m2 <= next_m2;
			OUT_DATA <= next_out;
			rv <= next_rv;
			ri <= next_ri;
			wsum <= next_wsum;
			vsum <= next_vsum;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence seq_reading;
		MEAS_VALID;
	endsequence
	sequence seq_result;
		##3 OUT_VALID;
	endsequence

	a_result_latency: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		seq_reading |-> seq_result) else $error("Result pulse missing after reading");
	a_result_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		OUT_VALID |-> $past(MEAS_VALID, 3)) else $error("Result pulse without reading");
	a_cal_ratio: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		MEAS_VALID && MEAS_IN[0].volt == `TLC_VCAL && MEAS_IN[0].curr == `TLC_ICAL
		|=> rv[0] inside {[18'd16376:18'd16384]} && ri[0] inside {[18'd16376:18'd16384]})
		else $error("Calibration point ratio not unity");
	a_add_lowers: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		OUT_VALID && !$past(c2.test) && ($past(c2.add) ^ $past(c2.flow_rev))
		|-> OUT_DATA[0].watt <= $past(m2[0].watt)) else $error("Loss sign wrong");
	a_sub_raises: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		OUT_VALID && !$past(c2.test) && !($past(c2.add) ^ $past(c2.flow_rev))
		|-> OUT_DATA[0].vars >= $past(m2[0].vars)) else $error("Loss sign wrong");
	a_terms_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		OUT_VALID && !$past(c2.iron_en) && !$past(c2.copper_en)
		|-> OUT_DATA[0] == $past(m2[0])) else $error("Disabled terms changed reading");
	a_zero_input: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		MEAS_VALID && MEAS_IN[0].volt == 16'h0 && MEAS_IN[0].curr == 16'h0
		|-> ##3 OUT_DATA[0].watt == $past(MEAS_IN[0].watt, 3)) else $error("Loss from zero");
	for (genvar g = 0; g < PHASES; g++) begin : g_chk
		a_test_bypass: assert property (@(posedge CLOCK) disable iff (SYS_RST)
			MEAS_VALID && ctrl.test |-> ##3 OUT_VALID && OUT_DATA[g].watt ==
			$past(MEAS_IN[g].watt, 3) && OUT_DATA[g].vars == $past(MEAS_IN[g].vars, 3))
			else $error("Test mode did not bypass");
	end
endmodule : tlc_top

// ===== test/tlc_meter_model.sv
// Meter-side reading source: one strobe per bench request, all phases together.
// Assumes the bench raises go for one cycle, synchronous to clk.
`timescale 1ns/10ps
module tlc_meter_model import tlc_pkg::*; (
	input wire logic clk,
	input wire logic go,
	input wire tlc_meas_t [2:0] meas,
	output logic valid,
	output tlc_meas_t [2:0] data
);
	initial begin
		valid = '0;
		data = '0;
	end
	// Between strobes the lines toggle, so a stale sample never looks valid
	always @(posedge clk) begin
		valid <= go;
		data <= go ? meas : ~data;
	end
endmodule : tlc_meter_model

// ===== test/tb_top.sv
// Bench for the loss block: settings over AXI4-Lite, readings, compensated results.
// Assumes the meter model supplies readings; losses checked within a small tolerance.
`timescale 1ns/10ps
module tb_top import tlc_pkg::*;;
	logic clock = '0;
	logic sys_rst = '1;
	logic go = '0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic awready, wready, bvalid, arready, rvalid, out_valid, mvalid;
	logic [1:0] bresp, rresp, r;
	tlc_meas_t [2:0] meas, mdata;
	tlc_res_t [2:0] res;
	logic [15:0] pct [4] = '{16'h0148, 16'h0290, 16'h0400, 16'h0800};
	int err_total = 0, num_checks = 0, nread = 0;
	tlc_meter_model model (.clk(clock), .go(go), .meas(meas), .valid(mvalid), .data(mdata));
	tlc_top #(.PHASES(3)) uut (.CLOCK(clock), .SYS_RST(sys_rst), .MEAS_VALID(mvalid),
		.MEAS_IN(mdata), .OUT_VALID(out_valid), .OUT_DATA(res), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
	initial begin
		forever #25 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("unexpected %0t %s", $time, msg);
		end
	endtask : chk
	task automatic time_out(input int n);
		if (n > 50) begin
			chk(1'b0, "no answer");
			stop_test();
		end
	endtask : time_out
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		awvalid <= '1;
		wvalid <= '1;
		bready <= '1;
		while (!done) begin
			@(posedge clock);
			if (awready) awvalid <= '0;
			if (wready) wvalid <= '0;
			if (bvalid) begin
				rs = bresp;
				bready <= '0;
				done = 1;
			end
			time_out(++n);
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		bit done;
		n = 0;
		done = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= '1;
		rready <= '1;
		while (!done) begin
			@(posedge clock);
			if (arready) arvalid <= '0;
			if (rvalid) begin
				v = rdata;
				rs = rresp;
				rready <= '0;
				done = 1;
			end
			time_out(++n);
		end
	endtask : rd
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a, d, r);
		chk(d === e && r === 2'b00, "register read");
	endtask : rchk
	function automatic bit near(input logic signed [31:0] g, input real b, input real l);
		real e;
		if (^g === 1'bx) return 0;
		e = b + l - $itor(g);
		if (e < 0) e = -e;
		return e <= ((l == 0.0) ? 0.0 : 0.002 * ((l < 0) ? -l : l) + 20.0);
	endfunction : near
	// Expected losses in real arithmetic; tolerance covers fixed-point truncation
	task automatic meas_run(input logic [4:0] c);
		int n;
		real vr, ir, wl, ql, s;
		n = 0;
		@(posedge clock);
		go <= '1;
		@(posedge clock);
		go <= '0;
		do begin
			@(posedge clock);
			#1;
			time_out(++n);
		end while (out_valid !== 1'b1);
		chk(n == 3, "result latency");
		nread++;
		for (int p = 0; p < 3; p++) begin
			vr = meas[p].volt / 12000.0;
			ir = meas[p].curr / 5000.0;
			wl = 600000.0 * (c[0] * vr * vr * pct[0] + c[1] * ir * ir * pct[1]) / 65536.0;
			ql = 600000.0 * (c[0] * vr ** 4 * pct[2] + c[1] * ir * ir * pct[3]) / 65536.0;
			s = c[4] ? 0.0 : ((c[2] ^ c[3]) ? -1.0 : 1.0);
			chk(near(res[p].watt, $signed(meas[p].watt), s * wl), "watt");
			chk(near(res[p].vars, $signed(meas[p].vars), s * ql), "vars");
		end
	endtask : meas_run
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		meas[0] = {16'h2ee0, 16'h1388, 32'h000f4240, 32'h00030d40};
		meas[1] = {16'h3138, 16'h09c4, 32'hfff3cb00, 32'hffff3cb0};
		meas[2] = {16'h2c88, 16'h1d4c, 32'h0007a120, 32'hfffb6c20};
		repeat (20) @(posedge clock);
		sys_rst <= '0;
		@(posedge clock);
		#1;
		chk(out_valid === 1'b0 && res === '0, "reset outputs");
		for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(8'(4 * i + 4), {16'hdead, pct[i]}, r);
			rchk(8'(4 * i + 4), {16'h0, pct[i]});
		end
		// Every enable, add/subtract and flow combination; phases unbalanced
		for (int c = 0; c < 16; c++) begin
			wr(8'h00, 32'habcd00e0 | c, r);
			rchk(8'h00, c);
			meas_run(5'(c));
		end
		// Dead phase 0: no voltage or current must leave its reading untouched
		meas[0] <= {16'h0000, 16'h0000, 32'h000f4240, 32'h00030d40};
		wr(8'h00, 32'h03, r);
		meas_run(5'h03);
		wr(8'h00, 32'h1f, r);
		meas_run(5'h1f);
		wr(8'h14, 32'h5555, r);
		chk(r === 2'b00, "status write");
		rchk(8'h14, nread);
		wr(8'h18, 32'h1, r);
		chk(r === 2'b10, "unmapped write");
		rd(8'h18, d, r);
		chk(r === 2'b10 && d === 32'h0, "unmapped read");
		stop_test();
	end
endmodule : tb_top
